// >>> design/dmt_pkg.sv
/*
  Package for the deadman fetch timer: register offsets, field positions,
  key patterns, reset values and the shared register-port carriers.
  Assumes a 32-bit register port with one-cycle strobes.
*/
package dmt_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] DMT_OFS_CONTROL  = 8'h00;
  localparam logic [7:0] DMT_OFS_PRECLEAR = 8'h10;
  localparam logic [7:0] DMT_OFS_CLEAR    = 8'h20;
  localparam logic [7:0] DMT_OFS_STATUS   = 8'h30;
  localparam logic [7:0] DMT_OFS_COUNT    = 8'h40;
  localparam logic [7:0] DMT_OFS_LIMIT    = 8'h60;
  localparam logic [7:0] DMT_OFS_WINDOW   = 8'h70;

  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int DMT_POS_ENABLE      = 15;
  localparam int DMT_POS_PRECLEAR_LO = 8;
  localparam int DMT_POS_CLEAR_LO    = 0;
  localparam int DMT_POS_PRE_ERR     = 7;
  localparam int DMT_POS_CLR_ERR     = 6;
  localparam int DMT_POS_EVENT       = 5;
  localparam int DMT_POS_WINDOW      = 0;
  localparam int DMT_POS_FUSE        = 3;

  //////////////////////////////////////////////////////////////////////////
  // key patterns and reset values
  localparam logic [7:0]  DMT_PRECLEAR_KEY = 8'h40;
  localparam logic [7:0]  DMT_CLEAR_KEY    = 8'h08;
  localparam logic [7:0]  DMT_KEY_RESET    = 8'h00;
  localparam logic [31:0] DMT_COUNT_RESET  = 32'h0000_0000;
  localparam logic [31:0] DMT_READ_ZERO    = 32'h0000_0000;

  // one register access from the port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dmt_req_type;

  // configuration word fields that the timer uses
  typedef struct packed {
    logic       enable_fuse;
    logic [4:0] limit_sel;
    logic [2:0] window_sel;
  } dmt_cfg_type;

endpackage

// >>> design/dmt_sync2.sv
/*
  Two-stage synchroniser for one level.
  Assumes the input is asynchronous to clock; only the second stage is read.
*/
`timescale 1ns/10ps
module dmt_sync2 (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // level in and out
  input  wire logic din,
  output logic      dout
);

  logic meta_r;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule // dmt_sync2

// >>> design/dmt_limit_calc.sv
/*
  Turns the 5-bit limit selector into a 32-bit match value and the 3-bit
  window selector into the count at which the clear window opens (limit minus limit>>(8-sel)).
  Assumes selectors are steady configuration values.
*/
`timescale 1ns/10ps
module dmt_limit_calc (
  // configuration
  input  wire logic [4:0]  limit_sel,
  input  wire logic [2:0]  window_sel,
  // derived values
  output logic      [31:0] limit,
  output logic      [31:0] window_open_at
);

  logic [31:0] win_len;

  // limit is 2^(sel+8) capped at the counter top; window is limit>>(8-sel)
  always_comb begin
    if (limit_sel > 5'h17) begin
      limit = 32'hFFFF_FFFF;
    end else begin
      limit = 32'h0000_0100 << limit_sel;
    end
    win_len        = limit >> (4'h8 - {1'b0, window_sel});
    window_open_at = limit - win_len;
  end

endmodule // dmt_limit_calc

// >>> design/dmt_top.sv
/*
  Deadman fetch timer: a 32-bit counter advanced by instruction fetches,
  cleared by a two-key sequence inside a window, raising a reset request.
  Assumes fetch_strobe and the configuration word come from logic on the
  same clock; configuration is steady while running.
*/
// Our own choices: strobed register access and the placing of the registers.
// Overview of operation
// - Control bit 15 enables the counter when one.
// - Enable resets to the fuse in configuration word bit 3.
// - Software enable writes act only while the fuse is zero.
// - Writing 0x40 to preclear key bits 15-8 arms the clear.
// - Any other preclear value sets the preclear error flag.
// - Preclear key clears on deadman event or completed clear sequence.
// - Clear key 0x08 after armed preclear zeros both keys and counter.
// - Wrong clear key sets clear error, stores value, keeps preclear while disabled.
// - Clear key written without arming sets the preclear error flag.
// - Clear key field zeroes on a deadman event.
// - Status bit 7 reads the preclear error flag.
// - Status bit 6 reads the clear error flag.
// - Status bit 5 sets on expiry or bad key while enabled.
// - Status bit 0 shows the clear window open.
// - Count register returns the live 32-bit counter.
// - Limit mirror register reads the configured limit selector.
// - Window mirror register reads the configured window selector.
// - Counter advances per instruction fetch until it meets the limit.
// - Counter is 32 bits; limit chosen by a 5-bit selector.
// - Once enabled, only device reset disables the timer.
// - A deadman event requests a processor reset.
`timescale 1ns/10ps
module dmt_top (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // register port
  input  wire dmt_pkg::dmt_req_type req,
  output logic               [31:0] rdata,
  // configuration word and core
  input  wire logic          [31:0] config_word_two,
  input  wire logic                 fetch_strobe,
  // reset request to the core
  output logic                      reset_request
);
  import dmt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // reset release
  logic        rst_n;
  dmt_sync2 u_rst_sync (
    .clock (clock),
    .rst_n (rstn),
    .din   (1'b1),
    .dout  (rst_n)
  );

  //////////////////////////////////////////////////////////////////////////
  // configuration decode
  dmt_cfg_type cfg;
  logic [31:0] limit;
  logic [31:0] open_at;

  // limit and window fields sit beside the fuse in the configuration word
  always_comb begin
    cfg.enable_fuse = config_word_two[DMT_POS_FUSE];
    cfg.window_sel  = config_word_two[6:4];
    cfg.limit_sel   = config_word_two[11:7];
  end

  dmt_limit_calc u_calc (
    .limit_sel      (cfg.limit_sel),
    .window_sel     (cfg.window_sel),
    .limit          (limit),
    .window_open_at (open_at)
  );

  //////////////////////////////////////////////////////////////////////////
  // state
  logic        enable_r,    enable_nxt;
  logic        strap_done_r, strap_done_nxt;
  logic [7:0]  pre_key_r,   pre_key_nxt;
  logic [7:0]  clr_key_r,   clr_key_nxt;
  logic        pre_err_r,   pre_err_nxt;
  logic        clr_err_r,   clr_err_nxt;
  logic        event_r,     event_nxt;
  logic        window_r,    window_nxt;
  logic [31:0] count_r,     count_nxt;
  logic [31:0] rdata_nxt;

  logic wr_ctrl;
  logic wr_pre;
  logic wr_clr;
  logic [7:0] pre_val;
  logic [7:0] clr_val;
  logic armed;
  logic good_clear;
  logic bad_key;
  logic expire;

  // write decode
  always_comb begin
    wr_ctrl = req.wr && (req.addr == DMT_OFS_CONTROL);
    wr_pre  = req.wr && (req.addr == DMT_OFS_PRECLEAR);
    wr_clr  = req.wr && (req.addr == DMT_OFS_CLEAR);
    pre_val = req.wdata[DMT_POS_PRECLEAR_LO +: 8];
    clr_val = req.wdata[DMT_POS_CLEAR_LO +: 8];
  end

  //////////////////////////////////////////////////////////////////////////
  // next-state logic for keys, flags, counter and window
  always_comb begin
    armed      = (pre_key_r == DMT_PRECLEAR_KEY);
    good_clear = wr_clr && armed && (clr_val == DMT_CLEAR_KEY);
    // bad key or out-of-sequence clear; early correct clear is bad too
    bad_key    = (wr_pre && pre_val != DMT_PRECLEAR_KEY)
               || (wr_clr && !armed)
               || (wr_clr && armed && clr_val != DMT_CLEAR_KEY)
               || (good_clear && !window_r);
    expire     = enable_r && fetch_strobe && (count_r >= limit - 32'h1)
               && !event_r;

    // strap caught on the first clock after reset release
    strap_done_nxt = 1'b1;
    enable_nxt     = enable_r;
    if (!strap_done_r) begin
      enable_nxt = cfg.enable_fuse;
    end else if (cfg.enable_fuse) begin
      enable_nxt = 1'b1;
    end else if (wr_ctrl && req.wdata[DMT_POS_ENABLE]) begin
      enable_nxt = 1'b1;
    end
    // no path clears enable_r except reset

    pre_key_nxt = pre_key_r;
    clr_key_nxt = clr_key_r;
    pre_err_nxt = pre_err_r;
    clr_err_nxt = clr_err_r;
    event_nxt   = event_r;
    count_nxt   = count_r;
    window_nxt  = window_r;

    // counter advances once per fetch while below the limit
    if (enable_r && fetch_strobe && !event_r && count_r < limit) begin
      count_nxt = count_r + 32'h1;
    end
    // window opens at limit minus interval
    if (enable_r && count_nxt >= open_at && !event_r) begin
      window_nxt = 1'b1;
    end

    if (wr_pre) begin
      pre_key_nxt = pre_val;
      if (pre_val != DMT_PRECLEAR_KEY) begin
        pre_err_nxt = 1'b1;
      end
    end
    if (wr_clr) begin
      if (!armed) begin
        pre_err_nxt = 1'b1;
        clr_key_nxt = clr_val;
      end else if (clr_val == DMT_CLEAR_KEY) begin
        pre_key_nxt = DMT_KEY_RESET;
        clr_key_nxt = DMT_KEY_RESET;
        count_nxt   = DMT_COUNT_RESET;
        window_nxt  = 1'b0;
      end else begin
        clr_err_nxt = 1'b1;
        clr_key_nxt = clr_val;
      end
    end

    // expiry or bad key raises the event while enabled; event wipes keys
    if ((expire || bad_key) && enable_r) begin
      event_nxt   = 1'b1;
      window_nxt  = 1'b0;
      pre_key_nxt = DMT_KEY_RESET;
      clr_key_nxt = DMT_KEY_RESET;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux; data stands in the cycle after the read strobe
  always_comb begin
    rdata_nxt = DMT_READ_ZERO;
    if (req.rd) begin
      unique case (req.addr)
        DMT_OFS_CONTROL:  rdata_nxt[DMT_POS_ENABLE] = enable_r;
        DMT_OFS_PRECLEAR: rdata_nxt[DMT_POS_PRECLEAR_LO +: 8] = pre_key_r;
        DMT_OFS_CLEAR:    rdata_nxt[DMT_POS_CLEAR_LO +: 8] = clr_key_r;
        DMT_OFS_STATUS: begin
          rdata_nxt[DMT_POS_PRE_ERR] = pre_err_r;
          rdata_nxt[DMT_POS_CLR_ERR] = clr_err_r;
          rdata_nxt[DMT_POS_EVENT]   = event_r;
          rdata_nxt[DMT_POS_WINDOW]  = window_r;
        end
        DMT_OFS_COUNT:  rdata_nxt = count_r;
        DMT_OFS_LIMIT:  rdata_nxt[4:0] = cfg.limit_sel;
        DMT_OFS_WINDOW: rdata_nxt[2:0] = cfg.window_sel;
        default:        rdata_nxt = DMT_READ_ZERO;  // unmapped reads zero
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers; flags are sticky until device reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
      enable_r     <= 1'b0;
      pre_key_r    <= DMT_KEY_RESET;
      clr_key_r    <= DMT_KEY_RESET;
      pre_err_r    <= 1'b0;
      clr_err_r    <= 1'b0;
      event_r      <= 1'b0;
      window_r     <= 1'b0;
      count_r      <= DMT_COUNT_RESET;
      rdata        <= DMT_READ_ZERO;
    end else begin
      strap_done_r <= strap_done_nxt;
      enable_r     <= enable_nxt;
      pre_key_r    <= pre_key_nxt;
      clr_key_r    <= clr_key_nxt;
      pre_err_r    <= pre_err_nxt;
      clr_err_r    <= clr_err_nxt;
      event_r      <= event_nxt;
      window_r     <= window_nxt;
      count_r      <= count_nxt;
      rdata        <= rdata_nxt;
    end
  end

  // reset request follows the event flag as a level
  assign reset_request = event_r;

endmodule // dmt_top

// >>> bench/dmt_fetch_model.sv
/*
  Instruction-fetch source standing in for the processor core.
  Assumes the timer samples fetch_strobe on the same rising clock edge.
*/
`timescale 1ns/10ps
module dmt_fetch_model (
  // clock
  input  wire logic        clock,
  // burst request from the bench
  input  wire logic        start,
  input  wire logic [15:0] num,
  // fetch pulses and burst status
  output logic             fetch_strobe,
  output logic             busy
);
  logic [15:0] left_r = 16'h0;
  logic        gap_r  = 1'b0;
  // one pulse per fetch; some fetches back to back, some spaced out
  assign fetch_strobe = (left_r != 16'h0) && !gap_r;
  assign busy         = (left_r != 16'h0);
  always_ff @(posedge clock) begin
    if (start) begin
      left_r <= num;
    end else if (fetch_strobe) begin
      left_r <= left_r - 16'h1;
    end
    gap_r <= fetch_strobe & left_r[2];
  end
endmodule // dmt_fetch_model

// >>> bench/dmt_top_assertions.sv
/*
  Port-level checks of the deadman fetch timer.
  Assumes the read data stand only in the cycle after a read strobe.
*/
`timescale 1ns/10ps
module dmt_top_assertions
  import dmt_pkg::*;
(
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rstn,
  // register port
  input wire dmt_pkg::dmt_req_type req,
  input wire logic          [31:0] rdata,
  // configuration and core
  input wire logic          [31:0] config_word_two,
  input wire logic                 fetch_strobe,
  input wire logic                 reset_request
);
  logic       rd_q;
  logic [7:0] ad_q;
  logic       en_seen;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // remember the read in flight and whether enable has been seen set
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_q    <= 1'b0;
      ad_q    <= 8'h00;
      en_seen <= 1'b0;
    end else begin
      rd_q <= req.rd;
      ad_q <= req.addr;
      if (rd_q && ad_q == DMT_OFS_CONTROL && rdata[15]) begin
        en_seen <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_idle_zero;
    !rd_q |-> rdata == DMT_READ_ZERO;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero outside a read");
  property p_limit_mirror;
    rd_q && ad_q == DMT_OFS_LIMIT |-> rdata == {27'h0, config_word_two[11:7]};
  endproperty
  a_limit_mirror: assert property (p_limit_mirror)
    else $error("limit mirror differs from configuration");
  property p_window_mirror;
    rd_q && ad_q == DMT_OFS_WINDOW |-> rdata == {29'h0, config_word_two[6:4]};
  endproperty
  a_window_mirror: assert property (p_window_mirror)
    else $error("window mirror differs from configuration");
  property p_ctrl_bits;
    rd_q && ad_q == DMT_OFS_CONTROL |-> rdata[14:0] == 15'h0
      && rdata[31:16] == 16'h0;
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits)
    else $error("control reads a bit beside enable");
  property p_enable_kept;
    rd_q && ad_q == DMT_OFS_CONTROL && en_seen |-> rdata[15];
  endproperty
  a_enable_kept: assert property (p_enable_kept)
    else $error("enable dropped without a reset");
  property p_pre_field;
    rd_q && ad_q == DMT_OFS_PRECLEAR |-> rdata[7:0] == 8'h00
      && rdata[31:16] == 16'h0;
  endproperty
  a_pre_field: assert property (p_pre_field)
    else $error("preclear key read outside its field");
  property p_clr_field;
    rd_q && ad_q == DMT_OFS_CLEAR |-> rdata[31:8] == 24'h0;
  endproperty
  a_clr_field: assert property (p_clr_field)
    else $error("clear key read outside its field");
  property p_status_bits;
    rd_q && ad_q == DMT_OFS_STATUS |-> rdata[4:1] == 4'h0
      && rdata[31:8] == 24'h0;
  endproperty
  a_status_bits: assert property (p_status_bits)
    else $error("status reads an unused bit");
  property p_req_sticky;
    reset_request |=> reset_request;
  endproperty
  a_req_sticky: assert property (p_req_sticky)
    else $error("reset request fell without a reset");
  // an event needs a key write or a fetch just before it
  property p_req_cause;
    $rose(reset_request) |-> $past(req.wr) || $past(req.wr, 2)
      || $past(fetch_strobe) || $past(fetch_strobe, 2);
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("reset request rose with no cause");
  c_event: cover property ($rose(reset_request));
  c_window: cover property (rd_q && ad_q == DMT_OFS_STATUS && rdata[0]);
  c_count: cover property (rd_q && ad_q == DMT_OFS_COUNT && rdata != 0);
endmodule // dmt_top_assertions
bind dmt_top dmt_top_assertions u_chk (
  .clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
  .config_word_two(config_word_two), .fetch_strobe(fetch_strobe),
  .reset_request(reset_request));

// >>> bench/test_deadman_fetch_timer.sv
/*
  Self-checking bench for the deadman fetch timer.
  Assumes limit = 2^(sel+8) and the window opening at half the limit.
*/
`timescale 1ns/10ps
module test_deadman_fetch_timer;
  import dmt_pkg::*;
  logic        clock  = 1'b0;
  logic        rstn   = 1'b0;
  dmt_req_type req    = '0;
  logic [31:0] cfg    = 32'h0000_0070;
  logic        fstart = 1'b0;
  logic [15:0] fnum   = 16'h0;
  logic [31:0] rdata;
  logic [31:0] rd_val;
  logic        fetch_strobe;
  logic        reset_request;
  logic        fbusy;
  int          err_count   = 0;
  int          checks_done = 0;
  always #2.5 clock = ~clock;
  dmt_top u_dut (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
    .config_word_two(cfg), .fetch_strobe(fetch_strobe),
    .reset_request(reset_request));
  dmt_fetch_model u_core (.clock(clock), .start(fstart), .num(fnum),
    .fetch_strobe(fetch_strobe), .busy(fbusy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  // data land at the edge after the strobe and stand one cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_val, exp);
  endtask
  task automatic fetch(input logic [15:0] n);
    @(posedge clock);
    fnum   <= n;
    fstart <= 1'b1;
    @(posedge clock);
    fstart <= 1'b0;
    repeat (2) @(posedge clock);
    while (fbusy) @(posedge clock);
    repeat (3) @(posedge clock);
  endtask
  // reset held 3 cycles, then room for the internal release
  task automatic restart(input logic [31:0] c, input logic en);
    @(posedge clock);
    rstn <= 1'b0;
    cfg  <= c;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    if (en) wr(DMT_OFS_CONTROL, 32'h0000_8000);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // mirrors, software enable and its lock
  task automatic test_mirrors;
    restart(32'h0000_0A70, 1'b0);
    rd_chk(DMT_OFS_LIMIT, 32'h14);
    rd_chk(DMT_OFS_WINDOW, 32'h7);
    rd_chk(DMT_OFS_CONTROL, 32'h0);
    rd_chk(8'h50, 32'h0);
    wr(DMT_OFS_CONTROL, 32'h0000_8000);
    rd_chk(DMT_OFS_CONTROL, 32'h0000_8000);
    wr(DMT_OFS_CONTROL, 32'h0);
    rd_chk(DMT_OFS_CONTROL, 32'h0000_8000);
    $display("mirrors and enable done");
  endtask
  // fuse set: enabled straight out of reset
  task automatic test_fuse;
    restart(32'h0000_0078, 1'b0);
    rd_chk(DMT_OFS_CONTROL, 32'h0000_8000);
    fetch(16'h5);
    rd_chk(DMT_OFS_COUNT, 32'h5);
    $display("fuse done");
  endtask
  // counting, window and the two-key clear in and out of the window
  task automatic test_clear;
    restart(32'h0000_0070, 1'b0);
    fetch(16'hA);
    rd_chk(DMT_OFS_COUNT, 32'h0);
    wr(DMT_OFS_CONTROL, 32'h0000_8000);
    fetch(16'h64);
    rd_chk(DMT_OFS_COUNT, 32'h64);
    rd_chk(DMT_OFS_STATUS, 32'h0);
    fetch(16'h1E);
    rd_chk(DMT_OFS_STATUS, 32'h1);
    wr(DMT_OFS_PRECLEAR, 32'h0000_4000);
    rd_chk(DMT_OFS_PRECLEAR, 32'h0000_4000);
    wr(DMT_OFS_CLEAR, 32'h08);
    rd_chk(DMT_OFS_COUNT, 32'h0);
    rd_chk(DMT_OFS_PRECLEAR, 32'h0);
    rd_chk(DMT_OFS_CLEAR, 32'h0);
    rd_chk(DMT_OFS_STATUS, 32'h0);
    wr(DMT_OFS_PRECLEAR, 32'h0000_4000);
    wr(DMT_OFS_CLEAR, 32'h08);
    rd_chk(DMT_OFS_STATUS, 32'h20);
    check({31'h0, reset_request}, 32'h1);
    $display("clear sequence done");
  endtask
  // wrong keys and out-of-order writes, enabled and disabled
  task automatic test_bad_keys;
    restart(32'h0000_0070, 1'b1);
    wr(DMT_OFS_PRECLEAR, 32'h0000_4100);
    rd_chk(DMT_OFS_STATUS, 32'hA0);
    rd_chk(DMT_OFS_PRECLEAR, 32'h0);
    restart(32'h0000_0070, 1'b1);
    wr(DMT_OFS_CLEAR, 32'h08);
    rd_chk(DMT_OFS_STATUS, 32'hA0);
    restart(32'h0000_0070, 1'b1);
    fetch(16'h82);
    wr(DMT_OFS_PRECLEAR, 32'h0000_4000);
    wr(DMT_OFS_CLEAR, 32'h09);
    rd(DMT_OFS_STATUS);
    check(rd_val & 32'hE0, 32'h60);
    rd_chk(DMT_OFS_CLEAR, 32'h0);
    // disabled: no event, so the wrong key stays visible
    restart(32'h0000_0070, 1'b0);
    wr(DMT_OFS_PRECLEAR, 32'h0000_4000);
    wr(DMT_OFS_CLEAR, 32'h09);
    rd_chk(DMT_OFS_CLEAR, 32'h09);
    rd_chk(DMT_OFS_PRECLEAR, 32'h0000_4000);
    rd_chk(DMT_OFS_STATUS, 32'h40);
    $display("bad keys done");
  endtask
  // expiry at the limit, then the counter stays frozen
  task automatic test_expiry;
    restart(32'h0000_0070, 1'b1);
    fetch(16'h100);
    check({31'h0, reset_request}, 32'h1);
    rd(DMT_OFS_STATUS);
    check(rd_val & 32'h20, 32'h20);
    fetch(16'h3);
    rd_chk(DMT_OFS_COUNT, 32'h100);
    $display("expiry done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    test_mirrors();
    test_fuse();
    test_clear();
    test_bad_keys();
    test_expiry();
    close_out();
  end
  // watchdog: the tests need about a thousand cycles
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule // test_deadman_fetch_timer
